// >>> ssw_debounce.sv
// Debouncer: output follows input once stable for a count of cycles
`default_nettype none
module ssw_debounce
    import ssw_pkg::*;
#(
    parameter int unsigned STABLE_CYC = DEBOUNCE_CYC,
    parameter logic        RST_VAL    = 1'b1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic clk_en,
    // Level in and out
    input  wire logic level_in,
    output var  logic level_out
);
    logic [DEB_W-1:0] cnt_r;
    logic [DEB_W-1:0] cnt_nxt;
    logic             level_r;
    logic             level_nxt;

    always_comb begin
        cnt_nxt   = '0;
        level_nxt = level_r;
        if (level_in != level_r) begin
            if (cnt_r == DEB_W'(STABLE_CYC - 1)) begin
                level_nxt = level_in;
            end else begin
                cnt_nxt = cnt_r + DEB_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_r   <= '0;
            level_r <= RST_VAL;
        end else if (clk_en) begin
            cnt_r   <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
endmodule // ssw_debounce
`default_nettype wire

// >>> ssw_host_model.sv
// Host processor model on the kick pin
`default_nettype none
module ssw_host_model (
    // Clock
    input  wire logic clk_sys,
    // Bench commands
    input  wire logic drive_en,
    input  wire logic kick_req,
    // Kick pin
    input  wire logic kick_pull,
    input  wire logic kick_pull_oe_n,
    output var  logic kick_level
);
    logic [1:0] high_r = 2'h0;
    logic [1:0] high_nxt;
    logic       float_r = 1'b0;
    always_comb begin
        high_nxt = kick_req ? 2'h3 : high_r - {1'b0, high_r != 2'h0};
    end
    always_ff @(posedge clk_sys) begin
        high_r <= high_nxt;
        float_r <= ~kick_level;
    end
    // Host wins over weak pull; undriven pin wanders
    always_comb begin
        if (drive_en) begin
            kick_level = (high_r != 2'h0);
        end else if (!kick_pull_oe_n) begin
            kick_level = kick_pull;
        end else begin
            kick_level = float_r;
        end
    end
endmodule // ssw_host_model
`default_nettype wire

// >>> ssw_pkg.sv
// Shared constants for the supply supervisor and watchdog
`default_nettype none
package ssw_pkg;
    // Timebase
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;

    // Reset hold period, least time, rounded up
    localparam int unsigned RESET_HOLD_MS   = 140;
    localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_MS * CYC_PER_MS;

    // Watchdog period, typical
    localparam int unsigned WDOG_PERIOD_MS  = 1600;
    localparam int unsigned WDOG_PERIOD_CYC = WDOG_PERIOD_MS * CYC_PER_MS;

    // Fraction of the period with the kick pin pulled high
    localparam int unsigned PULL_HIGH_DIV   = 8;

    // Manual request to reset, longest time, rounded down
    localparam int unsigned MANUAL_DELAY_NS = 5000;
    localparam int unsigned MANUAL_DELAY_CYC =
        (MANUAL_DELAY_NS * CYC_PER_US) / 1000;

    // Manual request debounce, least stable time, rounded up
    localparam int unsigned DEBOUNCE_NS     = 2000;
    localparam int unsigned DEBOUNCE_CYC    =
        (DEBOUNCE_NS * CYC_PER_US + 999) / 1000;

    // Counter widths
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned DEB_W           = 8;

    // Reset values of pin inputs after synchronising
    localparam logic        MANUAL_IDLE     = 1'b1;
    localparam logic        SUPPLY_LOW_RST  = 1'b1;
    localparam logic        SENSE_FAIL_RST  = 1'b1;
    localparam logic        KICK_RST        = 1'b0;

    // Reset output polarity default: active low
    localparam logic        RST_ACTIVE_HIGH = 1'b0;

    // Reset sequencer states
    typedef enum logic [1:0] {
        ST_SUPPLY,
        ST_MANUAL,
        ST_HOLD,
        ST_RUN
    } ssw_state_t;
endpackage : ssw_pkg
`default_nettype wire

// >>> ssw_supervisor.sv
// Supply supervisor: reset sequencer, manual reset, watchdog, fail flag
// Notes on behaviour
// - Reset is active the whole time the supply is below its trip level.
// - After the supply recovers, reset stays active at least 140 ms.
// - The manual request idles high and a low level activates reset.
// - A low manual request activates reset within 5 us.
// - The manual request is debounced and the hold starts on its release.
// - With no kick edge for a whole watchdog period the expired output is low.
// - Any kick edge before the period ends restarts the watchdog count.
// - The watchdog counts only while reset is released.
// - A low supply forces the expired output low regardless of the count.
// - A floating kick input disables the watchdog timeout.
// - The kick pin is pulled low for 7/8 of each period and high for 1/8.
// - The pull sequence repeats every period and stays enabled when the pin is driven.
`default_nettype none
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES     = RESET_HOLD_CYC,
    parameter int unsigned WDOG_CYCLES     = WDOG_PERIOD_CYC,
    parameter int unsigned DEB_CYCLES      = DEBOUNCE_CYC,
    parameter logic        RESET_HIGH      = RST_ACTIVE_HIGH
) (
    // Clock, reset, enable
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic clk_en,
    // Analog comparators as digital levels
    input  wire logic supply_below_trip,
    input  wire logic supply_fail_sense,
    // Manual reset push-button, pulled up outside
    input  wire logic manual_reset_request_n,
    // Watchdog kick pin, weak pull drive
    input  wire logic watchdog_kick_input,
    output var  logic watchdog_kick_pull,
    output var  logic watchdog_kick_pull_oe_n,
    // Outputs to the processor
    output var  logic reset_out,
    output var  logic watchdog_expired_out_n,
    output var  logic supply_fail_flag_n
);
    // Pull-high phase begins here
    localparam int unsigned PULL_START =
        WDOG_CYCLES - WDOG_CYCLES / PULL_HIGH_DIV;

    // Synchronised inputs; only the manual request is also debounced
    logic supply_low;
    logic sense_fail;
    logic man_sync;
    logic man_level;
    logic kick_level;

    ssw_sync #(
        .RST_VAL   (SUPPLY_LOW_RST)
    ) u_sync_supply (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .pin_in    (supply_below_trip),
        .level_out (supply_low)
    );

    ssw_sync #(
        .RST_VAL   (SENSE_FAIL_RST)
    ) u_sync_sense (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .pin_in    (supply_fail_sense),
        .level_out (sense_fail)
    );

    ssw_sync #(
        .RST_VAL   (MANUAL_IDLE)
    ) u_sync_manual (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .pin_in    (manual_reset_request_n),
        .level_out (man_sync)
    );

    ssw_debounce #(
        .STABLE_CYC (DEB_CYCLES),
        .RST_VAL    (MANUAL_IDLE)
    ) u_deb_manual (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .level_in   (man_sync),
        .level_out  (man_level)
    );

    ssw_sync #(
        .RST_VAL   (KICK_RST)
    ) u_sync_kick (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .pin_in    (watchdog_kick_input),
        .level_out (kick_level)
    );

    // Terminal count test shared by both counters
    function automatic logic at_last(input logic [CNT_W-1:0] cnt,
                                     input int unsigned       len);
        at_last = (cnt == CNT_W'(len - 1));
    endfunction

    // Reset sequencer state
    ssw_state_t       state_r;
    ssw_state_t       state_nxt;
    logic [CNT_W-1:0] hold_cnt_r;
    logic [CNT_W-1:0] hold_cnt_nxt;
    logic             reset_out_r;
    logic             reset_out_nxt;

    always_comb begin
        state_nxt    = state_r;
        hold_cnt_nxt = '0;
        if (supply_low) begin
            state_nxt = ST_SUPPLY;
        end else if (!man_level) begin
            state_nxt = ST_MANUAL;
        end else begin
            case (state_r)
                ST_SUPPLY: begin
                    state_nxt = ST_HOLD;
                end
                ST_MANUAL: begin
                    state_nxt = ST_HOLD;
                end
                ST_HOLD: begin
                    if (at_last(hold_cnt_r, HOLD_CYCLES)) begin
                        state_nxt = ST_RUN;
                    end else begin
                        hold_cnt_nxt = hold_cnt_r + CNT_W'(1);
                    end
                end
                default: begin
                    state_nxt = ST_RUN;
                end
            endcase
        end
        // Active level chosen at build time
        reset_out_nxt = (state_nxt != ST_RUN) ? RESET_HIGH : ~RESET_HIGH;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r     <= ST_SUPPLY;
            hold_cnt_r  <= '0;
            reset_out_r <= RESET_HIGH;
        end else if (clk_en) begin
            state_r     <= state_nxt;
            hold_cnt_r  <= hold_cnt_nxt;
            reset_out_r <= reset_out_nxt;
        end
    end

    // Watchdog state
    logic [CNT_W-1:0] wd_cnt_r;
    logic [CNT_W-1:0] wd_cnt_nxt;
    logic             wd_expired_r;
    logic             wd_expired_nxt;
    logic             kick_prev_r;
    logic             kick_prev_nxt;
    logic             kick_edge;
    logic             pull_r;
    logic             pull_nxt;
    logic             exp_n_r;
    logic             exp_n_nxt;

    always_comb begin
        kick_prev_nxt  = kick_level;
        kick_edge      = (kick_level != kick_prev_r);
        wd_cnt_nxt     = wd_cnt_r;
        wd_expired_nxt = wd_expired_r;
        if (state_r != ST_RUN) begin
            // Held at zero while reset is active
            wd_cnt_nxt     = '0;
            wd_expired_nxt = 1'b0;
        end else if (kick_edge) begin
            // Also catches edges made by the pull on an open pin
            wd_cnt_nxt     = '0;
            wd_expired_nxt = 1'b0;
        end else if (at_last(wd_cnt_r, WDOG_CYCLES)) begin
            wd_cnt_nxt     = '0;
            wd_expired_nxt = 1'b1;
        end else begin
            wd_cnt_nxt     = wd_cnt_r + CNT_W'(1);
        end
        // Low for the first 7/8, high for the last 1/8
        pull_nxt  = (wd_cnt_nxt >= CNT_W'(PULL_START));
        exp_n_nxt = ~(supply_low | wd_expired_nxt);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wd_cnt_r     <= '0;
            wd_expired_r <= 1'b0;
            kick_prev_r  <= KICK_RST;
            pull_r       <= 1'b0;
            exp_n_r      <= 1'b0;
        end else if (clk_en) begin
            wd_cnt_r     <= wd_cnt_nxt;
            wd_expired_r <= wd_expired_nxt;
            kick_prev_r  <= kick_prev_nxt;
            pull_r       <= pull_nxt;
            exp_n_r      <= exp_n_nxt;
        end
    end

    // Secondary supply flag, independent of everything else
    logic flg_n_r;
    logic flg_n_nxt;
    logic pull_oe_n_r;
    logic pull_oe_n_nxt;

    always_comb begin
        flg_n_nxt     = ~sense_fail;
        pull_oe_n_nxt = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flg_n_r     <= 1'b0;
            pull_oe_n_r <= 1'b1;
        end else if (clk_en) begin
            flg_n_r     <= flg_n_nxt;
            pull_oe_n_r <= pull_oe_n_nxt;
        end
    end

    // Output pins
    assign reset_out               = reset_out_r;
    assign watchdog_expired_out_n  = exp_n_r;
    assign supply_fail_flag_n      = flg_n_r;
    assign watchdog_kick_pull      = pull_r;
    assign watchdog_kick_pull_oe_n = pull_oe_n_r;
endmodule // ssw_supervisor
`default_nettype wire

// >>> ssw_supervisor_monitor.sv
// Checker for the supply supervisor ports
`default_nettype none
module ssw_supervisor_monitor
    import ssw_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYC,
    parameter int unsigned WDOG_CYCLES = WDOG_PERIOD_CYC,
    parameter logic        RESET_HIGH  = RST_ACTIVE_HIGH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    // Pins in
    input wire logic supply_below_trip,
    input wire logic supply_fail_sense,
    input wire logic manual_reset_request_n,
    input wire logic watchdog_kick_input,
    // Pins out
    input wire logic watchdog_kick_pull,
    input wire logic reset_out,
    input wire logic watchdog_expired_out_n,
    input wire logic supply_fail_flag_n
);
    logic        rst_act;
    logic        kick_r;
    logic [31:0] rel_r, rel_nxt;
    logic [31:0] wd_r, wd_nxt;
    assign rst_act = (reset_out == RESET_HIGH);
    // Quiet time in reset, time since last kick
    always_comb begin
        rel_nxt = 32'h0;
        wd_nxt = 32'h0;
        if (rst_act && !supply_below_trip && manual_reset_request_n) begin
            rel_nxt = rel_r + 32'h1;
        end
        if (!rst_act && watchdog_kick_input == kick_r) begin
            wd_nxt = wd_r + 32'(wd_r < 2 * WDOG_CYCLES);
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rel_r <= 32'h0;
            wd_r <= 32'h0;
            kick_r <= 1'b0;
        end else if (clk_en) begin
            rel_r <= rel_nxt;
            wd_r <= wd_nxt;
            kick_r <= watchdog_kick_input;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    AST_SUPPLY_RESET: assert property (
        supply_below_trip [*7] |-> rst_act)
        else $error("reset idle with supply low");
    AST_WDO_FORCED: assert property (
        supply_below_trip [*7] |-> !watchdog_expired_out_n)
        else $error("expired output high with supply low");
    AST_MANUAL_DELAY: assert property (
        $fell(manual_reset_request_n)
        |-> ##[1:50] (rst_act || manual_reset_request_n))
        else $error("manual request too slow");
    AST_HOLD_MIN: assert property (
        $fell(rst_act) |-> $past(rel_r) >= HOLD_CYCLES)
        else $error("reset hold too short");
    AST_HOLD_MAX: assert property (
        rel_r <= HOLD_CYCLES + 40)
        else $error("reset hold too long");
    AST_WDOG_EARLY: assert property (
        !rst_act && $fell(watchdog_expired_out_n)
        |-> wd_r + 3 >= WDOG_CYCLES)
        else $error("watchdog expired early");
    AST_WDOG_LATE: assert property (
        !rst_act && wd_r > WDOG_CYCLES + 8 |-> !watchdog_expired_out_n)
        else $error("watchdog did not expire");
    AST_PULL_PHASE: assert property (
        $rose(watchdog_kick_pull)
        |-> wd_r + 2 >= WDOG_CYCLES - WDOG_CYCLES / 8)
        else $error("kick pull high too early");
    AST_FAIL_FLAG: assert property (
        $stable(supply_fail_sense) [*8]
        |-> supply_fail_flag_n == !supply_fail_sense)
        else $error("fail flag wrong");
    cover property (!rst_act && $fell(watchdog_expired_out_n));
    cover property ($fell(rst_act));
    cover property ($rose(watchdog_kick_pull));
endmodule // ssw_supervisor_monitor
`default_nettype wire

// >>> ssw_supervisor_tb.sv
// Self-checking bench for the supply supervisor
`default_nettype none
module ssw_supervisor_tb
    import ssw_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int   HOLD = 50;
    localparam int   WDOG = 80;
    localparam logic ON   = RST_ACTIVE_HIGH;
    logic clk_sys, rstn, sup, sns, man_n, drv, kreq, en;
    logic pin, pull, poe_n, rst_o, exp_n, flag_n;
    int   mismatches, checks_done;
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    ssw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG),
        .DEB_CYCLES(4), .RESET_HIGH(ON)) ssw_supervisor_inst (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(en),
        .supply_below_trip(sup), .supply_fail_sense(sns),
        .manual_reset_request_n(man_n), .watchdog_kick_input(pin),
        .watchdog_kick_pull(pull), .watchdog_kick_pull_oe_n(poe_n),
        .reset_out(rst_o), .watchdog_expired_out_n(exp_n),
        .supply_fail_flag_n(flag_n));
    ssw_host_model ssw_host_model_inst (.clk_sys(clk_sys),
        .drive_en(drv), .kick_req(kreq), .kick_pull(pull),
        .kick_pull_oe_n(poe_n), .kick_level(pin));
    task automatic chk_bit(string what, logic exp, logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_cnt(string what, int lo, int hi, int got);
        checks_done++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Cycles until reset (0) or expired output (1) shows lvl
    task automatic wait_for(bit sel, logic lvl, int lim, output int n);
        n = 0;
        while ((sel ? exp_n : rst_o) !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic kick;
        @(posedge clk_sys) kreq <= 1'b1;
        @(posedge clk_sys) kreq <= 1'b0;
    endtask
    task automatic t_fail;
        cyc(8);
        chk_bit("fail idle", 1'b1, flag_n);
        @(posedge clk_sys) sns <= 1'b1;
        cyc(8);
        chk_bit("fail flag", 1'b0, flag_n);
        @(posedge clk_sys) sns <= 1'b0;
        cyc(8);
        chk_bit("fail clear", 1'b1, flag_n);
    endtask
    task automatic t_supply;
        int n;
        chk_bit("reset", ON, rst_o);
        chk_bit("expired", 1'b0, exp_n);
        @(posedge clk_sys) sup <= 1'b0;
        wait_for(0, !ON, 400, n);
        chk_cnt("hold", HOLD, HOLD + 10, n);
    endtask
    task automatic t_manual;
        int n;
        @(posedge clk_sys) man_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        man_n <= 1'b1;
        cyc(40);
        chk_bit("glitch", !ON, rst_o);
        @(posedge clk_sys) man_n <= 1'b0;
        wait_for(0, ON, 100, n);
        chk_cnt("manual delay", 1, 50, n);
        cyc(100);
        chk_bit("manual held", ON, rst_o);
        @(posedge clk_sys) man_n <= 1'b1;
        wait_for(0, !ON, 400, n);
        chk_cnt("manual hold", HOLD, HOLD + 40, n);
    endtask
    task automatic t_wdog;
        int n;
        wait_for(1, 1'b0, 200, n);
        chk_cnt("expiry", WDOG - 2, WDOG + 4, n);
        kick();
        cyc(8);
        chk_bit("kicked", 1'b1, exp_n);
        @(posedge clk_sys) en <= 1'b0;
        cyc(2 * WDOG);
        chk_bit("frozen", 1'b1, exp_n);
        @(posedge clk_sys) en <= 1'b1;
        repeat (4) begin
            cyc(60);
            chk_bit("serviced", 1'b1, exp_n);
            kick();
        end
    endtask
    task automatic t_float;
        int   rises;
        logic prev;
        logic low_seen;
        rises = 0;
        low_seen = 1'b0;
        cyc(4);
        prev = pull;
        @(posedge clk_sys) drv <= 1'b0;
        repeat (3 * WDOG) begin
            @(negedge clk_sys);
            rises += int'(pull === 1'b1 && prev === 1'b0);
            low_seen |= (exp_n !== 1'b1);
            prev = pull;
        end
        chk_bit("float expiry", 1'b0, low_seen);
        chk_cnt("pull pulses", 2, 4, rises);
        @(posedge clk_sys) drv <= 1'b1;
    endtask
    task automatic t_dip;
        int n;
        @(posedge clk_sys) sup <= 1'b1;
        wait_for(0, ON, 20, n);
        chk_cnt("dip delay", 1, 8, n);
        chk_bit("dip expired", 1'b0, exp_n);
        t_supply();
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {sup, sns, man_n, drv, kreq, en, rstn} = 7'h5A;
        mismatches = 0;
        checks_done = 0;
        cyc(16);
        @(posedge clk_sys) rstn <= 1'b1;
        t_fail();
        t_supply();
        t_manual();
        t_wdog();
        t_float();
        t_dip();
        print_verdict();
    end
    initial begin
        cyc(5000);
        mismatches++;
        print_verdict();
    end
endmodule // ssw_supervisor_tb
bind ssw_supervisor ssw_supervisor_monitor #(.HOLD_CYCLES(HOLD_CYCLES),
    .WDOG_CYCLES(WDOG_CYCLES), .RESET_HIGH(RESET_HIGH))
    ssw_supervisor_monitor_inst (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
    .supply_below_trip(supply_below_trip),
    .supply_fail_sense(supply_fail_sense),
    .manual_reset_request_n(manual_reset_request_n),
    .watchdog_kick_input(watchdog_kick_input),
    .watchdog_kick_pull(watchdog_kick_pull), .reset_out(reset_out),
    .watchdog_expired_out_n(watchdog_expired_out_n),
    .supply_fail_flag_n(supply_fail_flag_n));
`default_nettype wire

// >>> ssw_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module ssw_sync
    import ssw_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic clk_en,
    // Pin and result
    input  wire logic pin_in,
    output var  logic level_out
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic       level_r;
    logic       level_nxt;

    always_comb begin
        stage_nxt = {stage_r[1:0], pin_in};
        level_nxt = level_r;
        if (stage_r[1] == stage_r[2]) begin
            level_nxt = stage_r[2];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stage_r <= {3{RST_VAL}};
            level_r <= RST_VAL;
        end else if (clk_en) begin
            stage_r <= stage_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
endmodule // ssw_sync
`default_nettype wire
